//--- design/keq_pkg.sv
/*
 Constants, register map and lock states of the key event queue and lock block.
 Assumes a 125 MHz core clock and 8-bit register offsets on the register port.
*/
package keq_pkg;
   // Timing
   localparam int CLK_HZ     = 125_000_000;
   localparam int TICK_S     = 1;
   localparam int SEC_CYCLES = CLK_HZ * TICK_S;
   localparam int SEC_W      = 27;
   // Queue
   localparam int         QDEPTH = 10;
   localparam logic [3:0] Q_FULL = 4'hA;
   // Register offsets
   localparam logic [7:0] REG_CFG   = 8'h01;
   localparam logic [7:0] REG_STAT  = 8'h02;
   localparam logic [7:0] REG_LCK   = 8'h03;
   localparam logic [7:0] REG_EVT   = 8'h04;
   localparam logic [7:0] REG_UNLK1 = 8'h0E;
   localparam logic [7:0] REG_UNLK2 = 8'h0F;
   localparam logic [7:0] REG_LTMR  = 8'h10;
   localparam logic [7:0] REG_MAT0  = 8'h1D;
   localparam logic [7:0] REG_MAT1  = 8'h1E;
   localparam logic [7:0] REG_MAT2  = 8'h1F;
   localparam logic [7:0] REG_GEN0  = 8'h20;
   localparam logic [7:0] REG_GEN1  = 8'h21;
   localparam logic [7:0] REG_GEN2  = 8'h22;
   // Configuration bits; bits 3:0 enable the interrupt of the status flag of the same position
   localparam int CFG_OVR_MODE = 5;
   localparam int CFG_GPI_LCKM = 6;
   // Status flag bits
   localparam int ST_KEY = 0;
   localparam int ST_GPI = 1;
   localparam int ST_LCK = 2;
   localparam int ST_OVR = 3;
   localparam int ST_W   = 4;
   // Lock register and event byte
   localparam int LCK_EN_BIT = 6;
   localparam int PRESS_BIT  = 7;
   // Lock timer fields
   localparam int IVL_LSB  = 0;
   localparam int IVL_W    = 3;
   localparam int MASK_LSB = 3;
   localparam int MASK_W   = 5;
   // Event codes
   localparam logic [6:0] GPI_BASE = 7'h61;
   localparam logic [6:0] ROW_MUL  = 7'h0A;
   localparam int         NROWS    = 8;
   localparam int         NLINES   = 18;
   // Reset values
   localparam logic [7:0] CFG_RST  = 8'h00;
   localparam logic [7:0] LTMR_RST = 8'h00;

   typedef enum logic [3:0] {
      LK_OPEN  = 4'b0001,
      LK_IDLE  = 4'b0010,
      LK_MASK  = 4'b0100,
      LK_WAIT2 = 4'b1000
   } keq_lock_t;
endpackage : keq_pkg

//--- design/keq_top.sv
/*
 Key event queue, overflow handling and keypad lock state machine.
 Assumes key events arrive as one-cycle pulses from scanner logic on i_clk and
 register accesses arrive on the link clock, one at a time, each awaiting ack.
*/
// Overview of operation
// - Queue holds up to ten one-byte press or release events.
// - Events of keys on enabled matrix rows and columns are queued.
// - Input lines enabled in the input event enables queue their events.
// - Status register 0x02 flags key and input events when stored.
// - Register 0x03 bits 3:0 show the stored event count.
// - Register 0x04 returns head event: bit 7 press, bits 6:0 code.
// - Each event read decrements the count and shifts the queue.
// - Empty queue reads count 0 and event 0; host stops there.
// - Writing 1 to a status flag clears only that flag.
// - Event arriving on a full queue sets the overflow flag.
// - Overflow with its enable set asserts the low interrupt.
// - Overflow mode 1 appends at tail, dropping the oldest event.
// - Overflow mode 0 drops the new event, queue unchanged.
// - Writing 1 to bit 6 of 0x03 locks keypad recording.
// - Writing 0 to bit 6 of 0x03 unlocks at once.
// - Two unlock key registers accept any matrix or input code.
// - Lock timer bits 2:0 give the unlock key interval in seconds.
// - Lock timer bits 7:3 give the mask time in seconds.
// - Locked with mask set, first press interrupts and starts mask countdown.
// - Keylock flag and recording only after both unlock keys in order.
// - Mask expiry before correct keys returns to locked waiting.
// - Lock status is readable by the host.
// - Input codes 97 upward; matrix code is row times ten plus column plus one.
// - Input lock mode drops input events while locked.
// - Mask time of zero disables the mask feature.
`timescale 1ns/1ps
`default_nettype none
module keq_top #(
   parameter int SEC_CYCLES = keq_pkg::SEC_CYCLES
) (
   // Core clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   // Key events from scanner
   input  wire logic       i_evt_valid,
   input  wire logic       i_evt_press,
   input  wire logic       i_evt_is_input,
   input  wire logic [2:0] i_evt_row,
   input  wire logic [3:0] i_evt_col,
   input  wire logic [4:0] i_evt_line,
   // Register port on link clock
   input  wire logic       i_link_clk,
   input  wire logic       i_lk_req,
   input  wire logic       i_lk_we,
   input  wire logic [7:0] i_lk_addr,
   input  wire logic [7:0] i_lk_wdata,
   output logic            o_lk_busy,
   output logic            o_lk_ack,
   output logic [7:0]      o_lk_rdata,
   // Open-drain interrupt
   output logic            o_int_o,
   output logic            o_int_oe
);
   // Link domain request capture and ack return
   logic [1:0] lk_rst_ff;
   logic       lk_tgl_ff;
   logic       lk_we_ff;
   logic [7:0] lk_addr_ff;
   logic [7:0] lk_wdata_ff;
   logic [2:0] ack_s_ff;
   logic       ack_tgl_ff;
   logic [7:0] rdata_ff;
   logic       lk_rst_n;
   logic       ack_seen;

   assign lk_rst_n = lk_rst_ff[1];
   assign ack_seen = ack_s_ff[2] ^ ack_s_ff[1];

   always_ff @(posedge i_link_clk) begin
      lk_rst_ff <= {lk_rst_ff[0], i_reset_n};
   end

   always_ff @(posedge i_link_clk) begin
      if (!lk_rst_n) begin
         ack_s_ff   <= 3'h0;
         o_lk_busy  <= 1'b0;
         o_lk_ack   <= 1'b0;
         o_lk_rdata <= 8'h00;
         lk_tgl_ff  <= 1'b0;
      end else begin
         ack_s_ff <= {ack_s_ff[1:0], ack_tgl_ff};
         o_lk_ack <= ack_seen;
         if (ack_seen) begin
            o_lk_rdata <= rdata_ff;
            o_lk_busy  <= 1'b0;
         end else if (i_lk_req && !o_lk_busy) begin
            lk_tgl_ff <= ~lk_tgl_ff;
            o_lk_busy <= 1'b1;
         end
      end
   end

   // Held stable while busy, so the core may read them after the toggle syncs
   always_ff @(posedge i_link_clk) begin
      if (!lk_rst_n) begin
         lk_we_ff    <= 1'b0;
         lk_addr_ff  <= 8'h00;
         lk_wdata_ff <= 8'h00;
      end else if (i_lk_req && !o_lk_busy) begin
         lk_we_ff    <= i_lk_we;
         lk_addr_ff  <= i_lk_addr;
         lk_wdata_ff <= i_lk_wdata;
      end
   end

   // Core side of the handshake
   logic [2:0] req_s_ff;
   logic       acc;
   logic       wr;
   logic       rd;
   logic [7:0] wa;

   assign acc = req_s_ff[2] ^ req_s_ff[1];
   assign wr  = acc && lk_we_ff;
   assign rd  = acc && !lk_we_ff;
   assign wa  = lk_addr_ff;

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         req_s_ff   <= 3'h0;
         ack_tgl_ff <= 1'b0;
      end else begin
         req_s_ff <= {req_s_ff[1:0], lk_tgl_ff};
         if (acc) begin
            ack_tgl_ff <= ~ack_tgl_ff;
         end
      end
   end

   // Configuration registers
   logic [7:0]  cfg_ff;
   logic [6:0]  unlk1_ff;
   logic [6:0]  unlk2_ff;
   logic [7:0]  ltmr_ff;
   logic [17:0] mat_ff;
   logic [17:0] gen_ff;

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         cfg_ff   <= keq_pkg::CFG_RST;
         unlk1_ff <= 7'h00;
         unlk2_ff <= 7'h00;
         ltmr_ff  <= keq_pkg::LTMR_RST;
         mat_ff   <= 18'h00000;
         gen_ff   <= 18'h00000;
      end else if (wr) begin
         case (wa)
            keq_pkg::REG_CFG:   cfg_ff <= lk_wdata_ff;
            keq_pkg::REG_UNLK1: unlk1_ff <= lk_wdata_ff[6:0];
            keq_pkg::REG_UNLK2: unlk2_ff <= lk_wdata_ff[6:0];
            keq_pkg::REG_LTMR:  ltmr_ff <= lk_wdata_ff;
            keq_pkg::REG_MAT0:  mat_ff[7:0] <= lk_wdata_ff;
            keq_pkg::REG_MAT1:  mat_ff[15:8] <= lk_wdata_ff;
            keq_pkg::REG_MAT2:  mat_ff[17:16] <= lk_wdata_ff[1:0];
            keq_pkg::REG_GEN0:  gen_ff[7:0] <= lk_wdata_ff;
            keq_pkg::REG_GEN1:  gen_ff[15:8] <= lk_wdata_ff;
            keq_pkg::REG_GEN2:  gen_ff[17:16] <= lk_wdata_ff[1:0];
            default: ;
         endcase
      end
   end

   // Event qualification
   logic [3:0]  cnt_ff;
   logic [7:0]  q_ff [keq_pkg::QDEPTH];
   keq_pkg::keq_lock_t st_ff;
   logic        locked;
   logic [6:0]  code;
   logic        mat_en;
   logic        gen_en;
   logic        mat_push;
   logic        gen_push;
   logic        push;
   logic        key_press;

   assign locked = st_ff != keq_pkg::LK_OPEN;
   assign code = i_evt_is_input
      ? keq_pkg::GPI_BASE + 7'(i_evt_line)
      : 7'(i_evt_row) * keq_pkg::ROW_MUL + 7'(i_evt_col) + 7'h01;
   assign mat_en = mat_ff[i_evt_row] && mat_ff[keq_pkg::NROWS + 32'(i_evt_col)];
   assign gen_en = gen_ff[i_evt_line];
   assign mat_push = i_evt_valid && !i_evt_is_input && mat_en && !locked;
   assign gen_push = i_evt_valid && i_evt_is_input && gen_en
      && !(locked && cfg_ff[keq_pkg::CFG_GPI_LCKM]);
   assign push = mat_push || gen_push;
   assign key_press = i_evt_valid && i_evt_press
      && (i_evt_is_input ? gen_en : mat_en);

   // Queue control
   logic       do_pop;
   logic       full;
   logic       push_ok;
   logic       ovr;
   logic       q_shift;
   logic       q_wr;
   logic [3:0] q_widx;

   assign do_pop  = rd && wa == keq_pkg::REG_EVT && cnt_ff != 4'h0;
   assign full    = cnt_ff == keq_pkg::Q_FULL;
   assign push_ok = push && (!full || do_pop);
   assign ovr     = push && full && !do_pop;
   assign q_shift = do_pop || (ovr && cfg_ff[keq_pkg::CFG_OVR_MODE]);
   assign q_wr    = push_ok || (ovr && cfg_ff[keq_pkg::CFG_OVR_MODE]);
   assign q_widx  = q_shift ? cnt_ff - 4'h1 : cnt_ff;

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         cnt_ff <= 4'h0;
      end else begin
         cnt_ff <= cnt_ff + 4'(push_ok) - 4'(do_pop);
      end
   end

   for (genvar g = 0; g < keq_pkg::QDEPTH; g++) begin : g_q
      logic [7:0] up;
      if (g < keq_pkg::QDEPTH - 1) begin : g_mid
         assign up = q_ff[g+1];
      end else begin : g_last
         assign up = 8'h00;
      end
      always_ff @(posedge i_clk) begin
         if (!i_reset_n) begin
            q_ff[g] <= 8'h00;
         end else if (q_wr && q_widx == 4'(g)) begin
            q_ff[g] <= {i_evt_press, code};
         end else if (q_shift) begin
            q_ff[g] <= up;
         end
      end
   end

   // Lock state machine and second timers
   logic [keq_pkg::SEC_W-1:0]  sec_ff;
   logic                       tick;
   logic [keq_pkg::MASK_W-1:0] mcnt_ff;
   logic [keq_pkg::IVL_W-1:0]  icnt_ff;
   logic [keq_pkg::MASK_W-1:0] mask_val;
   logic [keq_pkg::IVL_W-1:0]  ivl_val;
   logic                       mask_exp;
   logic                       ivl_exp;
   logic                       unlock_ok;
   logic                       mask_irq;
   logic                       lock_wr;
   keq_pkg::keq_lock_t         back_st;

   assign tick = sec_ff == keq_pkg::SEC_W'(SEC_CYCLES - 1);
   assign mask_val = ltmr_ff[keq_pkg::MASK_LSB +: keq_pkg::MASK_W];
   assign ivl_val = ltmr_ff[keq_pkg::IVL_LSB +: keq_pkg::IVL_W];
   assign mask_exp = tick && mcnt_ff == keq_pkg::MASK_W'(1);
   assign ivl_exp = tick && icnt_ff <= keq_pkg::IVL_W'(1);
   assign lock_wr = wr && wa == keq_pkg::REG_LCK;
   assign unlock_ok = st_ff == keq_pkg::LK_WAIT2 && key_press
      && code == unlk2_ff && !lock_wr;
   assign mask_irq = st_ff == keq_pkg::LK_IDLE && key_press
      && mask_val != '0 && !lock_wr;
   assign back_st = (mcnt_ff != '0 && !mask_exp) ? keq_pkg::LK_MASK : keq_pkg::LK_IDLE;

   always_ff @(posedge i_clk) begin
      if (!i_reset_n || st_ff == keq_pkg::LK_OPEN || tick) begin
         sec_ff <= '0;
      end else begin
         sec_ff <= sec_ff + keq_pkg::SEC_W'(1);
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         st_ff   <= keq_pkg::LK_OPEN;
         mcnt_ff <= '0;
         icnt_ff <= '0;
      end else if (lock_wr) begin
         st_ff   <= lk_wdata_ff[keq_pkg::LCK_EN_BIT] ? keq_pkg::LK_IDLE : keq_pkg::LK_OPEN;
         mcnt_ff <= '0;
         icnt_ff <= '0;
      end else begin
         if (tick && mcnt_ff != '0) begin
            mcnt_ff <= mcnt_ff - keq_pkg::MASK_W'(1);
         end
         if (tick && icnt_ff != '0) begin
            icnt_ff <= icnt_ff - keq_pkg::IVL_W'(1);
         end
         case (st_ff)
            keq_pkg::LK_OPEN: ;
            keq_pkg::LK_IDLE: begin
               if (key_press) begin
                  mcnt_ff <= mask_val;
                  if (code == unlk1_ff) begin
                     st_ff   <= keq_pkg::LK_WAIT2;
                     icnt_ff <= ivl_val;
                  end else if (mask_val != '0) begin
                     st_ff <= keq_pkg::LK_MASK;
                  end
               end
            end
            keq_pkg::LK_MASK: begin
               if (key_press && code == unlk1_ff) begin
                  st_ff   <= keq_pkg::LK_WAIT2;
                  icnt_ff <= ivl_val;
               end else if (mask_exp) begin
                  st_ff <= keq_pkg::LK_IDLE;
               end
            end
            keq_pkg::LK_WAIT2: begin
               if (unlock_ok) begin
                  st_ff <= keq_pkg::LK_OPEN;
               end else if (key_press || ivl_exp) begin
                  st_ff <= back_st;
               end else if (mask_exp) begin
                  st_ff <= keq_pkg::LK_IDLE;
               end
            end
            default: st_ff <= keq_pkg::LK_IDLE;
         endcase
      end
   end

   // Status flags; a set in the clearing cycle wins
   logic [keq_pkg::ST_W-1:0] stat_ff;
   logic [keq_pkg::ST_W-1:0] st_set;
   logic [keq_pkg::ST_W-1:0] st_clr;

   always_comb begin
      st_set = '0;
      st_set[keq_pkg::ST_KEY] = mat_push || mask_irq;
      st_set[keq_pkg::ST_GPI] = gen_push;
      st_set[keq_pkg::ST_LCK] = unlock_ok;
      st_set[keq_pkg::ST_OVR] = ovr;
      st_clr = (wr && wa == keq_pkg::REG_STAT) ? lk_wdata_ff[keq_pkg::ST_W-1:0] : '0;
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         stat_ff <= '0;
      end else begin
         stat_ff <= (stat_ff & ~st_clr) | st_set;
      end
   end

   // Interrupt: each flag gated by the config bit of the same position
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_int_o  <= 1'b0;
         o_int_oe <= 1'b0;
      end else begin
         o_int_o  <= 1'b0;
         o_int_oe <= |(stat_ff & cfg_ff[keq_pkg::ST_W-1:0]);
      end
   end

   // Read data, captured when the access is taken
   logic [7:0] rmux;

   always_comb begin
      case (wa)
         keq_pkg::REG_CFG:   rmux = cfg_ff;
         keq_pkg::REG_STAT:  rmux = 8'(stat_ff);
         keq_pkg::REG_LCK:   rmux = 8'(cnt_ff) | (8'(locked) << keq_pkg::LCK_EN_BIT);
         keq_pkg::REG_EVT:   rmux = (cnt_ff == 4'h0) ? 8'h00 : q_ff[0];
         keq_pkg::REG_UNLK1: rmux = 8'(unlk1_ff);
         keq_pkg::REG_UNLK2: rmux = 8'(unlk2_ff);
         keq_pkg::REG_LTMR:  rmux = ltmr_ff;
         keq_pkg::REG_MAT0:  rmux = mat_ff[7:0];
         keq_pkg::REG_MAT1:  rmux = mat_ff[15:8];
         keq_pkg::REG_MAT2:  rmux = 8'(mat_ff[17:16]);
         keq_pkg::REG_GEN0:  rmux = gen_ff[7:0];
         keq_pkg::REG_GEN1:  rmux = gen_ff[15:8];
         keq_pkg::REG_GEN2:  rmux = 8'(gen_ff[17:16]);
         default:            rmux = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         rdata_ff <= 8'h00;
      end else if (rd) begin
         rdata_ff <= rmux;
      end
   end

   // Checks
   property p_cnt_max;
      @(posedge i_clk) disable iff (!i_reset_n) cnt_ff <= keq_pkg::Q_FULL;
   endproperty
   a_cnt_max: assert property (p_cnt_max) else $error("count above ten");

   property p_pop;
      @(posedge i_clk) disable iff (!i_reset_n)
         (do_pop && !push) |=> cnt_ff == $past(cnt_ff) - 4'h1;
   endproperty
   a_pop: assert property (p_pop) else $error("pop did not decrement");

   property p_empty;
      @(posedge i_clk) disable iff (!i_reset_n)
         (rd && wa == keq_pkg::REG_EVT && cnt_ff == 4'h0) |=> rdata_ff == 8'h00;
   endproperty
   a_empty: assert property (p_empty) else $error("empty read not zero");

   property p_ovr;
      @(posedge i_clk) disable iff (!i_reset_n)
         (push && full && !do_pop) |=> stat_ff[keq_pkg::ST_OVR] && cnt_ff == keq_pkg::Q_FULL;
   endproperty
   a_ovr: assert property (p_ovr) else $error("overflow flag missing");

   property p_keep;
      @(posedge i_clk) disable iff (!i_reset_n)
         (ovr && !cfg_ff[keq_pkg::CFG_OVR_MODE]) |=> q_ff[0] == $past(q_ff[0])
            && q_ff[keq_pkg::QDEPTH-1] == $past(q_ff[keq_pkg::QDEPTH-1]);
   endproperty
   a_keep: assert property (p_keep) else $error("mode 0 overflow changed queue");

   property p_wrap;
      @(posedge i_clk) disable iff (!i_reset_n)
         (ovr && cfg_ff[keq_pkg::CFG_OVR_MODE]) |=> q_ff[0] == $past(q_ff[1])
            && q_ff[keq_pkg::QDEPTH-1] == $past({i_evt_press, code});
   endproperty
   a_wrap: assert property (p_wrap) else $error("mode 1 overflow wrong");

   property p_irq;
      @(posedge i_clk) disable iff (!i_reset_n)
         (stat_ff[keq_pkg::ST_OVR] && cfg_ff[keq_pkg::ST_OVR]) |=> o_int_oe && !o_int_o;
   endproperty
   a_irq: assert property (p_irq) else $error("overflow interrupt missing");

   property p_lock;
      @(posedge i_clk) disable iff (!i_reset_n)
         (locked && i_evt_valid && !i_evt_is_input) |-> !push;
   endproperty
   a_lock: assert property (p_lock) else $error("locked key recorded");

   property p_unlock;
      @(posedge i_clk) disable iff (!i_reset_n)
         (lock_wr && !lk_wdata_ff[keq_pkg::LCK_EN_BIT]) |=> !locked;
   endproperty
   a_unlock: assert property (p_unlock) else $error("manual unlock failed");

   property p_w1c;
      @(posedge i_clk) disable iff (!i_reset_n)
         (st_clr[keq_pkg::ST_OVR] && !ovr) ##1 !st_clr[keq_pkg::ST_GPI]
            |-> !stat_ff[keq_pkg::ST_OVR];
   endproperty
   a_w1c: assert property (p_w1c) else $error("flag not cleared");
endmodule : keq_top
`default_nettype wire

//--- testbench/keq_host.sv
/*
 Host model: makes register accesses on the link clock port of the block.
 Assumes the bench supplies the link clock and starts calls after reset.
*/
`timescale 1ns/1ps
`default_nettype none
module keq_host (
   // Link clock
   input  wire logic       i_link_clk,
   // Answers from the block
   input  wire logic       i_lk_busy,
   input  wire logic       i_lk_ack,
   input  wire logic [7:0] i_lk_rdata,
   // Requests to the block
   output logic            o_lk_req,
   output logic            o_lk_we,
   output logic [7:0]      o_lk_addr,
   output logic [7:0]      o_lk_wdata
);
   initial begin
      {o_lk_req, o_lk_we, o_lk_addr, o_lk_wdata} = '0;
   end
   // Request drops once taken; qualifiers stand until the ack is seen
   task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] r);
      int n;
      n = 0;
      @(negedge i_link_clk);
      {o_lk_req, o_lk_we, o_lk_addr, o_lk_wdata} = {1'b1, we, a, d};
      // Busy is settled mid-cycle; low here means the next rising edge takes it
      while (i_lk_busy !== 1'b0 && n < 50) begin
         @(negedge i_link_clk);
         n++;
      end
      @(negedge i_link_clk);
      o_lk_req = 1'b0;
      do begin
         @(negedge i_link_clk);
         n++;
      end while (i_lk_ack !== 1'b1 && n < 100);
      r = (i_lk_ack === 1'b1) ? i_lk_rdata : 8'hXX;
      {o_lk_we, o_lk_addr, o_lk_wdata} = ~{we, a, d};
   endtask : xfer
endmodule : keq_host
`default_nettype wire

//--- testbench/keq_top_tb.sv
/*
 Bench for the key event queue and lock block: register calls plus key events.
 Assumes the host model above and a one-second tick of 60 core cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module keq_top_tb;
   logic       clk, link_clk, reset_n;
   logic       evt_valid, evt_press, evt_is_input;
   logic [2:0] evt_row;
   logic [3:0] evt_col;
   logic [4:0] evt_line;
   logic       lk_req, lk_we, lk_busy, lk_ack, int_o, int_oe;
   logic [7:0] lk_addr, lk_wdata, lk_rdata;
   int         bad_count, compares;

   keq_top #(.SEC_CYCLES(60)) dut (.i_clk(clk), .i_reset_n(reset_n),
      .i_evt_valid(evt_valid), .i_evt_press(evt_press), .i_evt_is_input(evt_is_input),
      .i_evt_row(evt_row), .i_evt_col(evt_col), .i_evt_line(evt_line),
      .i_link_clk(link_clk), .i_lk_req(lk_req), .i_lk_we(lk_we), .i_lk_addr(lk_addr),
      .i_lk_wdata(lk_wdata), .o_lk_busy(lk_busy), .o_lk_ack(lk_ack),
      .o_lk_rdata(lk_rdata), .o_int_o(int_o), .o_int_oe(int_oe));
   keq_host host (.i_link_clk(link_clk), .i_lk_busy(lk_busy), .i_lk_ack(lk_ack),
      .i_lk_rdata(lk_rdata), .o_lk_req(lk_req), .o_lk_we(lk_we), .o_lk_addr(lk_addr),
      .o_lk_wdata(lk_wdata));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #1.3;
      forever #3 link_clk = ~link_clk;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      host.xfer(1'b1, a, d, r);
      // Unknown data means the access never got its ack
      `CHK($isunknown(r), 1'b0)
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
      logic [7:0] r;
      host.xfer(1'b0, a, 8'h00, r);
      `CHK(r & m, e)
   endtask : rd
   // One-cycle event pulse; fields turn over once it has gone
   task automatic ev(input logic p, input logic inp, input logic [2:0] r,
                     input logic [3:0] c, input logic [4:0] l);
      @(negedge clk);
      {evt_valid, evt_press, evt_is_input, evt_row, evt_col, evt_line} = {1'b1, p, inp, r, c, l};
      @(negedge clk);
      evt_valid = 1'b0;
      {evt_press, evt_is_input, evt_row, evt_col, evt_line} = ~{p, inp, r, c, l};
   endtask : ev
   task automatic key(input logic [2:0] r, input logic [3:0] c);
      ev(1'b1, 1'b0, r, c, 5'h00);
   endtask : key
   // Eleven presses: codes 11 to 20, then 21
   task automatic fill;
      for (int i = 0; i < 10; i++) key(3'h1, 4'(i));
      key(3'h2, 4'h0);
   endtask : fill
   task automatic drain(input logic [7:0] first);
      for (int i = 0; i < 10; i++) rd(keq_pkg::REG_EVT, first + 8'(i));
   endtask : drain
   task automatic done(input string name);
      $display("test %s done", name);
   endtask : done
   task automatic results;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results

   initial begin
      repeat (30000) @(posedge clk);
      bad_count++;
      results();
   end

   initial begin
      {reset_n, evt_valid, evt_press, evt_is_input, evt_row, evt_col, evt_line} = '0;
      {bad_count, compares} = '0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      repeat (6) @(posedge link_clk);
      rd(keq_pkg::REG_STAT, 8'h00);
      rd(keq_pkg::REG_LCK, 8'h00);
      rd(keq_pkg::REG_EVT, 8'h00);
      rd(8'hFF, 8'h00);
      wr(keq_pkg::REG_MAT0, 8'hFF);
      wr(keq_pkg::REG_MAT1, 8'hFF);
      wr(keq_pkg::REG_MAT2, 8'h03);
      wr(keq_pkg::REG_GEN0, 8'hFF);
      key(3'h0, 4'h0);
      key(3'h3, 4'h1);
      ev(1'b0, 1'b1, 3'h0, 4'h0, 5'h00);
      ev(1'b1, 1'b1, 3'h0, 4'h0, 5'h08);
      rd(keq_pkg::REG_STAT, 8'h03);
      rd(keq_pkg::REG_LCK, 8'h03);
      rd(keq_pkg::REG_EVT, 8'h81);
      rd(keq_pkg::REG_LCK, 8'h02);
      rd(keq_pkg::REG_EVT, 8'hA0);
      rd(keq_pkg::REG_EVT, 8'h61);
      rd(keq_pkg::REG_EVT, 8'h00);
      rd(keq_pkg::REG_LCK, 8'h00);
      wr(keq_pkg::REG_STAT, 8'h01);
      rd(keq_pkg::REG_STAT, 8'h02);
      wr(keq_pkg::REG_STAT, 8'h02);
      rd(keq_pkg::REG_STAT, 8'h00);
      done("queue");
      wr(keq_pkg::REG_CFG, 8'h08);
      fill();
      rd(keq_pkg::REG_STAT, 8'h09);
      `CHK({int_oe, int_o}, 2'b10)
      rd(keq_pkg::REG_LCK, 8'h0A);
      drain(8'h8B);
      wr(keq_pkg::REG_STAT, 8'hFF);
      wr(keq_pkg::REG_CFG, 8'h28);
      fill();
      rd(keq_pkg::REG_LCK, 8'h0A);
      drain(8'h8C);
      done("overflow");
      wr(keq_pkg::REG_CFG, 8'h40);
      wr(keq_pkg::REG_STAT, 8'hFF);
      wr(keq_pkg::REG_LCK, 8'h40);
      key(3'h0, 4'h0);
      ev(1'b1, 1'b1, 3'h0, 4'h0, 5'h00);
      rd(keq_pkg::REG_LCK, 8'h40);
      rd(keq_pkg::REG_STAT, 8'h00, 8'h01);
      wr(keq_pkg::REG_LCK, 8'h00);
      key(3'h0, 4'h0);
      rd(keq_pkg::REG_LCK, 8'h01);
      rd(keq_pkg::REG_EVT, 8'h81);
      done("lock");
      wr(keq_pkg::REG_CFG, 8'h00);
      wr(keq_pkg::REG_UNLK1, 8'h05);
      wr(keq_pkg::REG_UNLK2, 8'h06);
      wr(keq_pkg::REG_LTMR, 8'h11);
      wr(keq_pkg::REG_STAT, 8'hFF);
      wr(keq_pkg::REG_LCK, 8'h40);
      key(3'h7, 4'h9);
      rd(keq_pkg::REG_STAT, 8'h01);
      wr(keq_pkg::REG_STAT, 8'hFF);
      key(3'h7, 4'h9);
      rd(keq_pkg::REG_STAT, 8'h00);
      key(3'h0, 4'h4);
      key(3'h0, 4'h5);
      rd(keq_pkg::REG_STAT, 8'h04, 8'h04);
      rd(keq_pkg::REG_LCK, 8'h00, 8'h40);
      done("unlock");
      wr(keq_pkg::REG_STAT, 8'hFF);
      wr(keq_pkg::REG_LCK, 8'h40);
      key(3'h7, 4'h9);
      key(3'h0, 4'h4);
      repeat (130) @(posedge clk);
      key(3'h0, 4'h5);
      rd(keq_pkg::REG_LCK, 8'h40, 8'h40);
      wr(keq_pkg::REG_STAT, 8'hFF);
      repeat (200) @(posedge clk);
      key(3'h7, 4'h9);
      rd(keq_pkg::REG_STAT, 8'h01, 8'h05);
      wr(keq_pkg::REG_LCK, 8'h00);
      done("timers");
      results();
   end
endmodule : keq_top_tb
`default_nettype wire
